// File: jis_pkg.sv
// constants for the jpeg interrupt status block
package jis_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MASKED = 8'h04;
  localparam logic [7:0] ADDR_RAW = 8'h08;
  localparam logic [7:0] ADDR_ENABLE = 8'h0C;

  // flag bit positions, shared by status, raw and enable registers; file output and level bits 12 to 14 are in status and raw only
  localparam int BIT_SIZE_OVER = 11;
  localparam int BIT_THRESH = 10;
  localparam int BIT_FULL = 9;
  localparam int BIT_EMPTY = 8;
  localparam int BIT_MARKER = 4;
  localparam int BIT_LB_OVF = 2;
  localparam int BIT_CODEC = 1;
  localparam int BIT_LB_IRQ = 0;
  localparam int BIT_FILE_OUT = 14;
  localparam int BIT_LEVEL_LO = 12;
  localparam int BIT_LEVEL_HI = 13;

  // control register fields
  localparam int BIT_CTRL_ENABLE = 0;
  localparam int BIT_CTRL_SWRST = 7;

  // reset values and fixed read patterns
  localparam logic [15:0] RAW_RESET = 16'h8080;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] MASKED_ONES = 16'h80E8;
  localparam logic [15:0] RAW_ONES = 16'h8080;
  localparam logic [15:0] ENABLE_MASK = 16'h0F17;
  localparam logic [15:0] W1C_MASK = 16'h0F10;
  localparam logic [15:0] CTRL_RW_MASK = 16'h0001;

  // fifo level field codes
  localparam logic [1:0] LEVEL_EMPTY = 2'h0;
  localparam logic [1:0] LEVEL_SMALL = 2'h1;
  localparam logic [1:0] LEVEL_QUARTER = 2'h2;
  localparam logic [1:0] LEVEL_HALF = 2'h3;

  // trigger threshold select codes
  localparam logic [1:0] TRIG_NONE = 2'h0;
  localparam logic [1:0] TRIG_SMALL = 2'h1;
  localparam logic [1:0] TRIG_QUARTER = 2'h2;
  localparam logic [1:0] TRIG_HALF = 2'h3;

  // smallest non-empty level band, in bytes
  localparam int LEVEL_SMALL_BYTES = 4;

  // number of sticky event flags
  localparam int NUM_FLAGS = 8;

endpackage : jis_pkg

// File: jis_sticky.sv
// bank of sticky event flags, set wins over clear
`timescale 1ns/1ps
module jis_sticky #(
  parameter int W = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  output logic [W-1:0] flag_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      // an event in the clearing cycle is kept
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          flag_out[i] <= 1'b0;
        end else begin
          flag_out[i] <= set_in[i] | (flag_out[i] & ~clr_in[i]);
        end
      end
    end
  endgenerate

endmodule : jis_sticky

// File: jis_wb_slave.sv
// classic wishbone slave handshake with registered read data
`timescale 1ns/1ps
module jis_wb_slave (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [15:0] rd_data_in,
  output logic wr_stb_out,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out
);

  logic req;

  // one ack per request, dropped the cycle after
  assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_stb_out = req & wb_we_in;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= req;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wb_dat_out <= 32'h00000000;
    end else if (req) begin
      wb_dat_out <= {16'h0000, rd_data_in};
    end
  end

endmodule : jis_wb_slave

// File: jis_irq_status.sv
// jpeg interrupt status, raw flags and enables with wishbone access
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Functional notes
// [R1] size overrun during encode sets bit 11
// [R2] fifo level over threshold sets bit 10
// [R3] fifo full sets sticky bit 9
// [R4] fifo empty sets sticky bit 8
// [R5] write one clears flag and raw copy
// [R6] masked status gated by matching enable bit
// [R7] raw register ignores enables, resets 0x8080
// [R8] marker read while decoding sets bit 4
// [R9] marker flag rises only when enabled
// [R10] software disables marker enable before clearing
// [R11] overflow flag cleared only by module reset
// [R12] overflow does not stop the module
// [R13] codec flag cleared by operation status read
// [R14] line buffer flag cleared by its status clear
// [R15] level field encodes four fifo level bands
// [R16] bit 14 shows file output in progress
// [R17] eight enable bits, all reset to zero
// [R18] software writes ones to reserved status bits
// [R19] interrupt request while any masked flag set
module jis_irq_status #(
  parameter int LEVEL_W = 9,
  parameter int FIFO_BYTES = 256
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic encoding_in,
  input wire logic decoding_in,
  input wire logic file_out_busy_in,
  input wire logic size_over_in,
  input wire logic [LEVEL_W-1:0] fifo_level_in,
  input wire logic [1:0] trig_sel_in,
  input wire logic marker_read_in,
  input wire logic lb_overflow_in,
  input wire logic codec_irq_in,
  input wire logic codec_status_read_in,
  input wire logic lb_irq_in,
  input wire logic lb_status_clear_in,
  output logic irq_out,
  output logic module_enable_out,
  output logic module_reset_out
);

  ////////////////////////////////////////////////////////////////////////
  // thresholds

  localparam logic [LEVEL_W-1:0] LVL_ZERO = '0;
  localparam logic [LEVEL_W-1:0] LVL_SMALL =
    LEVEL_W'(jis_pkg::LEVEL_SMALL_BYTES);
  localparam logic [LEVEL_W-1:0] LVL_QUARTER = LEVEL_W'(FIFO_BYTES / 4);
  localparam logic [LEVEL_W-1:0] LVL_HALF = LEVEL_W'(FIFO_BYTES / 2);
  localparam logic [LEVEL_W-1:0] LVL_FULL = LEVEL_W'(FIFO_BYTES);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic wr_stb;
  logic [15:0] rd_data;
  logic [15:0] wdata;
  logic [15:0] lane_mask;
  logic hit_ctrl;
  logic hit_masked;
  logic hit_raw;
  logic hit_enable;
  logic wr_ctrl;
  logic wr_masked;
  logic wr_enable;

  logic [15:0] enables;
  logic [15:0] next_enables;
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic sw_reset;

  logic [LEVEL_W-1:0] level;
  logic file_out;
  logic [1:0] level_code;
  logic above_small;
  logic above_quarter;
  logic above_half;
  logic at_least_small;
  logic at_least_quarter;
  logic at_least_half;
  logic is_empty;
  logic is_full;
  logic trig_hit;

  logic [15:0] flags;
  logic [15:0] raw_word;
  logic [15:0] masked_word;
  logic [15:0] w1c;
  logic [jis_pkg::NUM_FLAGS-1:0] set_vec;
  logic [jis_pkg::NUM_FLAGS-1:0] clr_vec;
  logic [jis_pkg::NUM_FLAGS-1:0] flag_vec;
  logic any_masked;

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  jis_wb_slave u_bus (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in),
    .rd_data_in(rd_data),
    .wr_stb_out(wr_stb),
    .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out)
  );

  assign wdata = wb_dat_in[15:0];
  assign lane_mask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign hit_ctrl = (wb_adr_in == jis_pkg::ADDR_CTRL);
  assign hit_masked = (wb_adr_in == jis_pkg::ADDR_MASKED);
  assign hit_raw = (wb_adr_in == jis_pkg::ADDR_RAW);
  assign hit_enable = (wb_adr_in == jis_pkg::ADDR_ENABLE);
  assign wr_ctrl = wr_stb & hit_ctrl;
  assign wr_masked = wr_stb & hit_masked;
  assign wr_enable = wr_stb & hit_enable;

  ////////////////////////////////////////////////////////////////////////
  // enable and control registers

  // [R17] enables, zero after reset
  assign next_enables = wr_enable
    ? ((enables & ~lane_mask) | (wdata & lane_mask & jis_pkg::ENABLE_MASK))
    : enables;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      enables <= jis_pkg::ENABLE_RESET;
    end else begin
      enables <= next_enables;
    end
  end

  assign next_ctrl = wr_ctrl
    ? ((ctrl & ~lane_mask) | (wdata & lane_mask & jis_pkg::CTRL_RW_MASK))
    : ctrl;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctrl <= jis_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // reset bit is write only and needs the module enabled
  assign sw_reset = wr_ctrl & wb_sel_in[0] & wdata[jis_pkg::BIT_CTRL_SWRST]
    & ctrl[jis_pkg::BIT_CTRL_ENABLE];

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      module_reset_out <= 1'b0;
      module_enable_out <= 1'b0;
    end else begin
      module_reset_out <= sw_reset;
      module_enable_out <= next_ctrl[jis_pkg::BIT_CTRL_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // live status capture

  // levels registered so raw reads 0x8080 straight after reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      level <= LVL_ZERO;
      file_out <= 1'b0;
    end else begin
      level <= fifo_level_in;
      file_out <= file_out_busy_in;
    end
  end

  assign at_least_small = (level >= LVL_SMALL);
  assign at_least_quarter = (level >= LVL_QUARTER);
  assign at_least_half = (level >= LVL_HALF);
  assign above_small = (level > LVL_SMALL);
  assign above_quarter = (level > LVL_QUARTER);
  assign above_half = (level > LVL_HALF);
  assign is_empty = (level == LVL_ZERO);
  assign is_full = (level >= LVL_FULL);

  // [R15] level band code
  assign level_code = at_least_half ? jis_pkg::LEVEL_HALF
    : at_least_quarter ? jis_pkg::LEVEL_QUARTER
    : at_least_small ? jis_pkg::LEVEL_SMALL
    : jis_pkg::LEVEL_EMPTY;

  // [R2] selected trigger threshold
  assign trig_hit = (trig_sel_in == jis_pkg::TRIG_SMALL) ? above_small
    : (trig_sel_in == jis_pkg::TRIG_QUARTER) ? above_quarter
    : (trig_sel_in == jis_pkg::TRIG_HALF) ? above_half
    : 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // sticky event flags

  // index order: 7 size, 6 thresh, 5 full, 4 empty,
  // 3 marker, 2 overflow, 1 codec, 0 line buffer
  // [R1] size overrun only while encoding; encoding is not stopped
  assign set_vec[7] = encoding_in & size_over_in;
  assign set_vec[6] = trig_hit;
  // [R3] full seen at least once
  assign set_vec[5] = is_full;
  // [R4] empty seen at least once
  assign set_vec[4] = is_empty;
  // [R8] [R9] marker while decoding and enabled
  assign set_vec[3] = marker_read_in & decoding_in
    & enables[jis_pkg::BIT_MARKER];
  // [R12] overflow only reported, nothing here halts the module
  assign set_vec[2] = lb_overflow_in;
  // [R13] codec core interrupt
  assign set_vec[1] = codec_irq_in;
  // [R14] line buffer interrupt
  assign set_vec[0] = lb_irq_in;

  // [R5] write one to clear, byte lane gated
  assign w1c = wr_masked ? (wdata & lane_mask & jis_pkg::W1C_MASK) : 16'h0000;

  assign clr_vec[7] = w1c[jis_pkg::BIT_SIZE_OVER];
  assign clr_vec[6] = w1c[jis_pkg::BIT_THRESH];
  assign clr_vec[5] = w1c[jis_pkg::BIT_FULL];
  assign clr_vec[4] = w1c[jis_pkg::BIT_EMPTY];
  // [R10] clearing marker leaves enable to software
  assign clr_vec[3] = w1c[jis_pkg::BIT_MARKER];
  // [R11] overflow cleared by module reset alone
  assign clr_vec[2] = sw_reset;
  // [R13] cleared by status read
  assign clr_vec[1] = codec_status_read_in;
  // [R14] cleared with line buffer status
  assign clr_vec[0] = lb_status_clear_in;

  jis_sticky #(
    .W(jis_pkg::NUM_FLAGS)
  ) u_flags (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .set_in(set_vec),
    .clr_in(clr_vec),
    .flag_out(flag_vec)
  );

  ////////////////////////////////////////////////////////////////////////
  // register views

  always_comb begin
    flags = 16'h0000;
    flags[jis_pkg::BIT_SIZE_OVER] = flag_vec[7];
    flags[jis_pkg::BIT_THRESH] = flag_vec[6];
    flags[jis_pkg::BIT_FULL] = flag_vec[5];
    flags[jis_pkg::BIT_EMPTY] = flag_vec[4];
    flags[jis_pkg::BIT_MARKER] = flag_vec[3];
    flags[jis_pkg::BIT_LB_OVF] = flag_vec[2];
    flags[jis_pkg::BIT_CODEC] = flag_vec[1];
    flags[jis_pkg::BIT_LB_IRQ] = flag_vec[0];
  end

  // [R7] raw view ignores the enables
  // [R16] file output status in bit 14
  always_comb begin
    raw_word = flags | jis_pkg::RAW_ONES;
    raw_word[jis_pkg::BIT_FILE_OUT] = file_out;
    raw_word[jis_pkg::BIT_LEVEL_HI:jis_pkg::BIT_LEVEL_LO] = level_code;
  end

  // [R6] masked view, reserved bits read one
  // [R18] ones written to reserved bits are ignored
  always_comb begin
    masked_word = (flags & enables) | jis_pkg::MASKED_ONES;
    masked_word[jis_pkg::BIT_FILE_OUT] = file_out;
    masked_word[jis_pkg::BIT_LEVEL_HI:jis_pkg::BIT_LEVEL_LO] = level_code;
  end

  // unmapped offsets answer with zero
  assign rd_data = hit_ctrl ? ctrl
    : hit_masked ? masked_word
    : hit_raw ? raw_word
    : hit_enable ? enables
    : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // interrupt request

  // [R19] any masked flag raises the request
  assign any_masked = |(flags & enables);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= any_masked;
    end
  end

endmodule : jis_irq_status

// File: jis_irq_status_props.sv
// bus and interrupt checker for the jpeg interrupt status block
`timescale 1ns/1ps
module jis_props #(
  parameter int LEVEL_W = 9,
  parameter int FIFO_BYTES = 256
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic irq_out,
  input wire logic module_enable_out,
  input wire logic module_reset_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  logic take;
  assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
  sequence s_read(a);
    take && !wb_we_in && wb_adr_in == a ##1 wb_ack_out;
  endsequence
  sequence s_swrst;
    take && wb_we_in && wb_adr_in == 8'h00 && wb_sel_in[0] &&
      wb_dat_in[7] && module_enable_out;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_ack_answer: assert property (take |=> wb_ack_out)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_out |-> $past(take))
    else $error("ack without request");
  a_dat_hold: assert property (!$past(take) |-> $stable(wb_dat_out))
    else $error("read data moved without request");
  a_raw_fixed: assert property (s_read(8'h08) |->
    (wb_dat_out & 32'hFFFF80E8) == 32'h00008080)
    else $error("raw fixed bits wrong");
  a_masked_ones: assert property (s_read(8'h04) |->
    (wb_dat_out & 32'hFFFF80E8) == 32'h000080E8)
    else $error("masked fixed bits wrong");
  a_irq_match: assert property (s_read(8'h04) |->
    irq_out == |(wb_dat_out[15:0] & 16'h0F17))
    else $error("irq disagrees with masked flags");
  a_unmapped_zero: assert property
    (take && !wb_we_in && wb_adr_in[7:4] != 4'h0 |=> wb_dat_out == 0)
    else $error("unmapped read not zero");
  a_swrst_pulse: assert property (s_swrst |=> module_reset_out)
    else $error("no module reset pulse");
  a_swrst_short: assert property (module_reset_out |=> !module_reset_out)
    else $error("module reset longer than one cycle");
endmodule : jis_props

bind jis_irq_status jis_props #(.LEVEL_W(LEVEL_W), .FIFO_BYTES(FIFO_BYTES))
  i_jis_props (.clock_in(clock_in), .rst_in(rst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .irq_out(irq_out),
  .module_enable_out(module_enable_out),
  .module_reset_out(module_reset_out));

// File: jis_irq_status_tb_top.sv
// self-checking bench for the jpeg interrupt status block
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("[ERR] %0t got %h exp %h", $time, g, e); \
    end \
  end
module jis_irq_status_tb_top;
  localparam int FB = 256;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, enc = 0, dec = 0;
  logic fbusy = 0, sover = 0, marker = 0, lbovf = 0, cirq = 0, crd = 0;
  logic lbirq = 0, lbclr = 0, ack, irq, men;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, rdat, rd;
  logic [8:0] lvl = 9'h008;
  logic [1:0] trig = 0;
  int failures = 0, check_count = 0;
  // one row per case, marker twice (enabled, disabled), overflow tested apart: bit, enables, expected raw flag
  int rb[8] = '{11, 10, 9, 8, 4, 4, 1, 0};
  logic [15:0] ren[8] = '{16'h0F17, 16'h0000, 16'h0F17, 16'h0F17,
    16'h0F17, 16'h0000, 16'h0002, 16'h0000};
  logic [15:0] rraw[8] = '{16'h0800, 16'h0400, 16'h0200, 16'h0100,
    16'h0010, 16'h0000, 16'h0002, 16'h0001};
  int lv[4] = '{0, 4, FB / 4, FB / 2};
  jis_irq_status #(.LEVEL_W(9), .FIFO_BYTES(FB)) i_jis_irq_status (
    .clock_in(clk), .rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .encoding_in(enc),
    .decoding_in(dec), .file_out_busy_in(fbusy), .size_over_in(sover),
    .fifo_level_in(lvl), .trig_sel_in(trig), .marker_read_in(marker),
    .lb_overflow_in(lbovf), .codec_irq_in(cirq),
    .codec_status_read_in(crd), .lb_irq_in(lbirq),
    .lb_status_clear_in(lbclr), .irq_out(irq), .module_enable_out(men),
    .module_reset_out());
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hF;
    dat <= {16'h0000, d};
    // only the watchdog ends a wait that never gets an ack
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 0; stb <= 0;
    @(posedge clk);
  endtask : wb
  task poke(input int b, input logic v);
    case (b)
      11: begin enc <= v; sover <= v; end
      10: trig <= {1'b0, v};
      9: lvl <= v ? 9'h100 : 9'h008;
      8: lvl <= v ? 9'h000 : 9'h008;
      4: begin dec <= v; marker <= v; end
      2: lbovf <= v;
      1: cirq <= v;
      default: lbirq <= v;
    endcase
  endtask : poke
  task pulse(input int b);
    poke(b, 1);
    @(posedge clk);
    poke(b, 0);
    repeat (3) @(posedge clk);
  endtask : pulse
  // enables off first, then ones to every status bit
  task clr;
    wb(1, jis_pkg::ADDR_ENABLE, 16'h0000);
    wb(1, jis_pkg::ADDR_MASKED, 16'hFFFF);
    crd <= 1; lbclr <= 1;
    @(posedge clk);
    crd <= 0; lbclr <= 0;
  endtask : clr
  task tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    wb(0, jis_pkg::ADDR_RAW, 0);
    `CHK(rd, 32'h00008080)
    wb(0, jis_pkg::ADDR_ENABLE, 0);
    `CHK(rd, 32'h00000000)
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      clr();
      wb(1, jis_pkg::ADDR_ENABLE, ren[i]);
      pulse(rb[i]);
      wb(0, jis_pkg::ADDR_RAW, 0);
      `CHK(rd[15:0], 16'h9080 | rraw[i])
      wb(0, jis_pkg::ADDR_MASKED, 0);
      `CHK(rd[15:0], 16'h90E8 | (rraw[i] & ren[i]))
      `CHK(irq, |(rraw[i] & ren[i]))
      $display("row %0d done", i);
    end
    clr();
    pulse(2);
    wb(1, jis_pkg::ADDR_MASKED, 16'hFFFF);
    wb(0, jis_pkg::ADDR_RAW, 0);
    `CHK(rd[15:0], 16'h9084)
    wb(1, jis_pkg::ADDR_CTRL, 16'h0001);
    wb(1, jis_pkg::ADDR_CTRL, 16'h0081);
    `CHK(men, 1'b1)
    wb(0, jis_pkg::ADDR_RAW, 0);
    `CHK(rd[15:0], 16'h9080)
    $display("overflow test done");
    wb(1, jis_pkg::ADDR_ENABLE, 16'h0010);
    pulse(4);
    wb(1, jis_pkg::ADDR_ENABLE, 16'h0000);
    wb(0, jis_pkg::ADDR_RAW, 0);
    `CHK(rd[15:0], 16'h9090)
    wb(1, jis_pkg::ADDR_MASKED, 16'h0010);
    wb(0, jis_pkg::ADDR_RAW, 0);
    `CHK(rd[15:0], 16'h9080)
    $display("marker test done");
    fbusy <= 1;
    for (int k = 0; k < 4; k++) begin
      lvl <= lv[k][8:0];
      repeat (3) @(posedge clk);
      wb(0, jis_pkg::ADDR_RAW, 0);
      `CHK(rd[14:12], {1'b1, k[1:0]})
    end
    $display("level test done");
    wb(1, 8'h10, 16'hFFFF);
    wb(0, 8'h10, 0);
    `CHK(rd, 32'h00000000)
    $display("unmapped test done");
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule : jis_irq_status_tb_top
